// file: verilog/ssp_top.sv
// Purpose: Serial load latches, dividers, phase comparator and power-down gating.
// Assumes: Pins are asynchronous to clk; the five non-serial pins pass two flip-flops first, the serial pins feed the shifter directly.
// Notes: The pump outputs idle low means high impedance.
`timescale 1ns/1ps
module ssp_top
    import ssp_pkg::*;
#(
    parameter logic high_freq_variant = 1'b0
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic phase_polarity_select,
    input wire logic power_down_n,
    input wire logic prescaler_in,
    input wire logic reference_in,
    output logic pump_up,
    output logic pump_down,
    output logic pump_switch_out,
    output logic lock_indicator,
    output logic comparator_monitor_out,
    output logic power_saving,
    output logic ratio_select
);
    function automatic logic ssp_done(input logic [15:0] cnt, input logic [15:0] lim);
        return ({1'b0, cnt} + 17'h00001) >= {1'b0, lim};
    endfunction : ssp_done

    // ****************************************
    // Serial shifter on the link clock
    // ****************************************
    ssp_word_if wbus ();

    ssp_shifter u_shift (
        .sclk(sclk),
        .serial_data(serial_data),
        .wbus(wbus)
    );

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // The word itself is not synchronised: the serial clock is parked while the
    // strobe moves, so the word is static when the synchronised edge arrives.
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic sync3_reg;
    logic le_s;
    logic pol_s;
    logic pdn_s;
    logic pre_s;
    logic ref_s;
    logic le_rise;
    logic pre_rise;
    logic ref_rise;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            // The power-down stages start at the pin's idle high level, so no false
            // power-saving request follows reset.
            sync1_reg <= 5'h04;
            sync2_reg <= 5'h04;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= {load_strobe, phase_polarity_select, power_down_n,
                          prescaler_in, reference_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg[4];
        end
    end

    assign le_s = sync2_reg[4];
    assign pol_s = sync2_reg[3];
    assign pdn_s = sync2_reg[2];
    assign pre_s = sync2_reg[1];
    assign ref_s = sync2_reg[0];
    assign le_rise = le_s && !sync3_reg;

    // ****************************************
    // Core state
    // ****************************************
    logic [18:0] main_latch_reg, main_latch_next;
    logic [18:0] ref_latch_reg, ref_latch_next;
    logic [7:0] pre_cnt_reg, pre_cnt_next;
    logic [15:0] a_cnt_reg, a_cnt_next;
    logic [15:0] b_cnt_reg, b_cnt_next;
    logic [15:0] r_cnt_reg, r_cnt_next;
    logic pre_last_reg, pre_last_next;
    logic ref_last_reg, ref_last_next;
    logic fv_reg, fv_next;
    logic fr_reg, fr_next;
    logic up_reg, up_next;
    logic dn_reg, dn_next;
    logic pump_up_reg, pump_up_next;
    logic pump_down_reg, pump_down_next;
    logic switch_reg, switch_next;
    logic lock_reg, lock_next;
    logic mon_reg, mon_next;
    logic psave_reg, psave_next;
    logic [7:0] pre_base;
    logic [7:0] cur_mod;
    logic [15:0] a_val;
    logic [15:0] b_val;
    logic [15:0] r_val;

    assign pre_rise = pre_s && !pre_last_reg;
    assign ref_rise = ref_s && !ref_last_reg;
    assign a_val = 16'(main_latch_reg[SSP_ACNT_LSB +: SSP_ACNT_W]);
    assign b_val = 16'(main_latch_reg[SSP_BCNT_LSB +: SSP_BCNT_W]);
    assign r_val = 16'(ref_latch_reg[SSP_RCNT_LSB +: SSP_RCNT_W]);

    always_comb begin
        main_latch_next = main_latch_reg;
        ref_latch_next = ref_latch_reg;
        // copy on strobe rise, control bit picks latch, else hold.
        if (le_rise) begin
            if (wbus.word[SSP_CTL_POS] == SSP_CTL_MAIN) begin
                main_latch_next = wbus.word[SSP_WORD_W-1:1];
            end else begin
                ref_latch_next = wbus.word[SSP_WORD_W-1:1];
            end
        end
        // modulus pair, the larger one while swallowing.
        if (high_freq_variant) begin
            pre_base = main_latch_reg[SSP_RATIO_POS] ? SSP_PRE_HI_BIG : SSP_PRE_HI_SMALL;
        end else begin
            pre_base = main_latch_reg[SSP_RATIO_POS] ? SSP_PRE_LO_BIG : SSP_PRE_LO_SMALL;
        end
        cur_mod = (a_cnt_reg < a_val) ? pre_base + 8'h01 : pre_base;
        pre_last_next = pre_s;
        ref_last_next = ref_s;
        pre_cnt_next = pre_cnt_reg;
        a_cnt_next = a_cnt_reg;
        b_cnt_next = b_cnt_reg;
        r_cnt_next = r_cnt_reg;
        fv_next = 1'b0;
        fr_next = 1'b0;
        if (pre_rise) begin
            if (pre_cnt_reg + 8'h01 >= cur_mod) begin
                pre_cnt_next = SSP_PRE_CNT_RST;
                if (ssp_done(b_cnt_reg, b_val)) begin
                    b_cnt_next = SSP_CNT_RST;
                    a_cnt_next = SSP_CNT_RST;
                    fv_next = 1'b1;
                end else begin
                    b_cnt_next = b_cnt_reg + 16'h0001;
                    if (a_cnt_reg < a_val) begin
                        a_cnt_next = a_cnt_reg + 16'h0001;
                    end
                end
            end else begin
                pre_cnt_next = pre_cnt_reg + 8'h01;
            end
        end
        if (ref_rise) begin
            if (ssp_done(r_cnt_reg, r_val)) begin
                r_cnt_next = SSP_CNT_RST;
                fr_next = 1'b1;
            end else begin
                r_cnt_next = r_cnt_reg + 16'h0001;
            end
        end
        // Simple phase-frequency detector: the later edge cancels the earlier.
        up_next = up_reg;
        dn_next = dn_reg;
        if (fr_reg && !fv_reg) begin
            up_next = !dn_reg;
            dn_next = 1'b0;
        end else if (fv_reg && !fr_reg) begin
            dn_next = !up_reg;
            up_next = 1'b0;
        end else if (fv_reg && fr_reg) begin
            up_next = 1'b0;
            dn_next = 1'b0;
        end
        // power saving only entered while the pump is idle.
        psave_next = psave_reg;
        if (pdn_s) begin
            psave_next = 1'b0;
        end else if (!up_reg && !dn_reg) begin
            psave_next = 1'b1;
        end
        if (psave_reg) begin
            pre_cnt_next = SSP_PRE_CNT_RST;
            a_cnt_next = SSP_CNT_RST;
            b_cnt_next = SSP_CNT_RST;
            r_cnt_next = SSP_CNT_RST;
            fv_next = 1'b0;
            fr_next = 1'b0;
            up_next = 1'b0;
            dn_next = 1'b0;
        end
        pump_up_next = pol_s ? up_reg : dn_reg;
        pump_down_next = pol_s ? dn_reg : up_reg;
        switch_next = le_s;
        // low only while a pump pulse is active.
        lock_next = !(up_reg || dn_reg);
        mon_next = ref_latch_reg[SSP_MONSEL_POS] ? fv_reg : fr_reg;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            main_latch_reg <= SSP_MAIN_LATCH_RST;
            ref_latch_reg <= SSP_REF_LATCH_RST;
            pre_cnt_reg <= SSP_PRE_CNT_RST;
            a_cnt_reg <= SSP_CNT_RST;
            b_cnt_reg <= SSP_CNT_RST;
            r_cnt_reg <= SSP_CNT_RST;
            pre_last_reg <= 1'b0;
            ref_last_reg <= 1'b0;
            fv_reg <= 1'b0;
            fr_reg <= 1'b0;
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
            pump_up_reg <= 1'b0;
            pump_down_reg <= 1'b0;
            switch_reg <= 1'b0;
            lock_reg <= 1'b1;
            mon_reg <= 1'b0;
            psave_reg <= 1'b0;
        end else begin
            main_latch_reg <= main_latch_next;
            ref_latch_reg <= ref_latch_next;
            pre_cnt_reg <= pre_cnt_next;
            a_cnt_reg <= a_cnt_next;
            b_cnt_reg <= b_cnt_next;
            r_cnt_reg <= r_cnt_next;
            pre_last_reg <= pre_last_next;
            ref_last_reg <= ref_last_next;
            fv_reg <= fv_next;
            fr_reg <= fr_next;
            up_reg <= up_next;
            dn_reg <= dn_next;
            pump_up_reg <= pump_up_next;
            pump_down_reg <= pump_down_next;
            switch_reg <= switch_next;
            lock_reg <= lock_next;
            mon_reg <= mon_next;
            psave_reg <= psave_next;
        end
    end

    assign pump_up = pump_up_reg;
    assign pump_down = pump_down_reg;
    assign pump_switch_out = switch_reg;
    assign lock_indicator = lock_reg;
    assign comparator_monitor_out = mon_reg;
    assign power_saving = psave_reg;
    assign ratio_select = main_latch_reg[SSP_RATIO_POS];

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    main_load_a: assert property (le_rise && wbus.word[0] |=>
        main_latch_reg == $past(wbus.word[SSP_WORD_W-1:1]))
        else $error("Main latch not loaded.");
    ctl_select_a: assert property (le_rise && !wbus.word[0] |=>
        $stable(main_latch_reg) && ref_latch_reg == $past(wbus.word[SSP_WORD_W-1:1]))
        else $error("Wrong latch chosen.");
    latch_hold_a: assert property (!le_rise |=>
        $stable(main_latch_reg) && $stable(ref_latch_reg))
        else $error("Latch changed without strobe.");
    polarity_swap_a: assert property (##1 pump_up_reg ==
        ($past(pol_s) ? $past(up_reg) : $past(dn_reg)))
        else $error("Pump polarity wrong.");
    switch_follow_a: assert property (##1 switch_reg == $past(le_s))
        else $error("Switch not following strobe.");
    lock_shape_a: assert property (up_reg || dn_reg |=> !lock_reg)
        else $error("Lock not low during pump pulse.");
    normal_run_a: assert property (pdn_s |=> !psave_reg)
        else $error("Power saving while input high.");
    pd_gate_a: assert property ($rose(psave_reg) |->
        $past(!up_reg && !dn_reg && !pdn_s))
        else $error("Power down entered with active pump.");
    modulus_range_a: assert property (pre_cnt_reg < cur_mod
        || $past(le_rise, 1) || $past(le_rise, 2))
        else $error("Prescaler count beyond modulus.");
    monitor_mirror_a: assert property (##1 mon_reg ==
        ($past(ref_latch_reg[SSP_MONSEL_POS]) ? $past(fv_reg) : $past(fr_reg)))
        else $error("Monitor output wrong.");

    load_main_c: cover property (le_rise && wbus.word[0]);
    load_ref_c: cover property (le_rise && !wbus.word[0]);
    enter_pd_c: cover property ($rose(psave_reg));
    pump_pulse_c: cover property ($fell(lock_reg));
endmodule : ssp_top

// file: shared/ssp_pkg.sv
// Purpose: Constants shared by the synthesizer serial load and pump control block.
// Assumes: A serial word of SSP_WORD_W bits, control bit in the least significant place.
// Notes: Field positions other than SSP_CTL_POS refer to the latched payload, the serial word above the control bit.
package ssp_pkg;
    // ****************************************
    // Serial word layout
    // ****************************************
    localparam int SSP_WORD_W = 20;
    localparam int SSP_CTL_POS = 0;
    localparam logic SSP_CTL_MAIN = 1'b1;
    localparam int SSP_PAY_W = 19;
    localparam int SSP_RATIO_POS = 18;
    localparam int SSP_BCNT_LSB = 7;
    localparam int SSP_BCNT_W = 11;
    localparam int SSP_ACNT_LSB = 0;
    localparam int SSP_ACNT_W = 7;
    localparam int SSP_MONSEL_POS = 18;
    localparam int SSP_RCNT_LSB = 4;
    localparam int SSP_RCNT_W = 14;
    // ****************************************
    // Prescaler moduli and reset values
    // ****************************************
    localparam logic [7:0] SSP_PRE_LO_SMALL = 8'h40;
    localparam logic [7:0] SSP_PRE_LO_BIG = 8'h80;
    localparam logic [7:0] SSP_PRE_HI_SMALL = 8'h20;
    localparam logic [7:0] SSP_PRE_HI_BIG = 8'h40;
    localparam logic [18:0] SSP_MAIN_LATCH_RST = 19'h00000;
    localparam logic [18:0] SSP_REF_LATCH_RST = 19'h00000;
    localparam logic [7:0] SSP_PRE_CNT_RST = 8'h00;
    localparam logic [15:0] SSP_CNT_RST = 16'h0000;
endpackage : ssp_pkg

// file: shared/ssp_word_if.sv
// Purpose: Carries the serial shift word from the link domain to the core.
// Assumes: The word is quasi-static whenever the load strobe moves.
// Notes: Driven by the shifter, read by the core.
`timescale 1ns/1ps
interface ssp_word_if;
    import ssp_pkg::*;
    logic [SSP_WORD_W-1:0] word;
    modport src (output word);
    modport dst (input word);
endinterface : ssp_word_if

// file: verilog/ssp_shifter.sv
// Purpose: Serial shift register on the serial clock.
// Assumes: The host holds the serial clock low while the load strobe toggles.
// Notes: No reset exists in this domain; the word is only used after a full load.
`timescale 1ns/1ps
module ssp_shifter
    import ssp_pkg::*;
(
    input wire logic sclk,
    input wire logic serial_data,
    ssp_word_if.src wbus
);
    logic [SSP_WORD_W-1:0] shift_reg;
    logic [SSP_WORD_W-1:0] shift_next;
    logic [SSP_WORD_W:0] fill_reg;
    logic [SSP_WORD_W:0] fill_next;

    // sample on rise, MSB enters first.
    always_comb begin
        shift_next = {shift_reg[SSP_WORD_W-2:0], serial_data};
        // No reset exists here, so ones march in to mark when the word is fully known.
        fill_next = {fill_reg[SSP_WORD_W-1:0], 1'b1};
    end

    always_ff @(posedge sclk) begin
        shift_reg <= shift_next;
        fill_reg <= fill_next;
    end

    assign wbus.word = shift_reg;

    shift_order_a: assert property (@(posedge sclk) fill_reg[SSP_WORD_W] |->
        shift_reg[SSP_WORD_W-1:1] == $past(shift_reg[SSP_WORD_W-2:0])
        && shift_reg[0] == $past(serial_data))
        else $error("Shift order broken.");
endmodule : ssp_shifter

// file: verif/ssp_host_model.sv
// Purpose: Host model driving the three-wire serial load port.
// Assumes: Serial clock period of 6 ns, parked low outside frames.
// Notes: The data line shows the inverse of the last bit once released.
`timescale 1ns/1ps
module ssp_host_model
    import ssp_pkg::*;
(
    output logic sclk,
    output logic serial_data,
    output logic load_strobe
);
    // ****************************************
    // Serial load tasks
    // ****************************************
    initial begin
        sclk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end

    task automatic shift(input logic [SSP_WORD_W-1:0] w);
        for (int i = SSP_WORD_W - 1; i >= 0; i--) begin
            serial_data = w[i];
            #3.0 sclk = 1'b1;
            #3.0 sclk = 1'b0;
        end
        #1.0 serial_data = ~w[0];
    endtask : shift

    task automatic set_strobe(input logic v);
        sclk = 1'b0;
        #7.0 load_strobe = v;
        #7.0;
    endtask : set_strobe
endmodule : ssp_host_model

// file: verif/ssp_top_tb_top.sv
// Purpose: Self-checking bench for the serial load and pump control block.
// Assumes: Inputs change on the falling clock edge; host model owns the serial pins.
// Notes: Waits are bounded so a stuck output ends the run with a report.
`timescale 1ns/1ps
module ssp_top_tb_top
    import ssp_pkg::*;
();
    logic clk, nrst, phase_polarity_select, power_down_n, prescaler_in, reference_in;
    wire logic sclk, serial_data, load_strobe;
    logic pump_up, pump_down, pump_switch_out, lock_indicator;
    logic comparator_monitor_out, power_saving, ratio_select;
    int fails = 0;
    int compares = 0;
    int mon_hits = 0;
    int edges;

    ssp_host_model host_u (.sclk(sclk), .serial_data(serial_data), .load_strobe(load_strobe));
    ssp_top dut_u (.clk(clk), .nrst(nrst), .sclk(sclk), .serial_data(serial_data),
        .load_strobe(load_strobe), .phase_polarity_select(phase_polarity_select),
        .power_down_n(power_down_n), .prescaler_in(prescaler_in),
        .reference_in(reference_in), .pump_up(pump_up), .pump_down(pump_down),
        .pump_switch_out(pump_switch_out), .lock_indicator(lock_indicator),
        .comparator_monitor_out(comparator_monitor_out), .power_saving(power_saving),
        .ratio_select(ratio_select));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Counting at the falling edge sees each one-cycle pulse exactly once.
    always @(negedge clk) begin
        if (comparator_monitor_out === 1'b1) mon_hits++;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic pulse();
        host_u.set_strobe(1'b1);
        cyc(6);
        chk("switch_on", 16'h1, {15'h0, pump_switch_out});
        host_u.set_strobe(1'b0);
        cyc(6);
        chk("switch_off", 16'h0, {15'h0, pump_switch_out});
    endtask : pulse

    task automatic do_load(input logic [SSP_WORD_W-1:0] w);
        host_u.shift(w);
        pulse();
    endtask : do_load

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        nrst = 1'b0;
        phase_polarity_select = 1'b1;
        power_down_n = 1'b1;
        prescaler_in = 1'b0;
        reference_in = 1'b0;
        cyc(4);
        nrst = 1'b1;
        cyc(2);
        chk("psave_rst", 16'h0, {15'h0, power_saving});
        cyc(2);
        chk("lock_rst", 16'h1, {15'h0, lock_indicator});
        chk("pump_rst", 16'h0, {14'h0, pump_up, pump_down});
        // Main latch with the large modulus selected.
        do_load(20'h80001);
        chk("ratio_main", 16'h1, {15'h0, ratio_select});
        // Reference latch: monitor shows the main divider, ratio must not move.
        do_load(20'h80020);
        chk("ratio_ref", 16'h1, {15'h0, ratio_select});
        // Shifting alone leaves the latches untouched.
        host_u.shift(20'h00001);
        cyc(6);
        chk("ratio_hold", 16'h1, {15'h0, ratio_select});
        pulse();
        chk("ratio_clear", 16'h0, {15'h0, ratio_select});
        // One reference edge starts an up pulse that waits for the divider.
        reference_in = 1'b1;
        cyc(10);
        chk("pump_norm", 16'h2, {14'h0, pump_up, pump_down});
        chk("lock_low", 16'h0, {15'h0, lock_indicator});
        chk("mon_fr", 16'h0, mon_hits[15:0]);
        phase_polarity_select = 1'b0;
        cyc(4);
        chk("pump_swap", 16'h1, {14'h0, pump_up, pump_down});
        power_down_n = 1'b0;
        cyc(10);
        chk("pd_gated", 16'h0, {15'h0, power_saving});
        // Prescaler edges until the divider pulse returns the pump to idle.
        edges = 0;
        while (edges < 200 && (pump_up !== 1'b0 || pump_down !== 1'b0)) begin
            prescaler_in = 1'b1;
            cyc(8);
            prescaler_in = 1'b0;
            cyc(8);
            edges++;
        end
        if (edges >= 200) begin
            fails++;
        end
        chk("pre_edges", {8'h0, SSP_PRE_LO_SMALL}, edges[15:0]);
        cyc(4);
        chk("pd_enter", 16'h1, {15'h0, power_saving});
        chk("lock_high", 16'h1, {15'h0, lock_indicator});
        chk("mon_fv", 16'h1, mon_hits[15:0]);
        power_down_n = 1'b1;
        cyc(4);
        chk("pd_leave", 16'h0, {15'h0, power_saving});
        // Swallow: B of two and A of one need two moduli, the first one longer.
        do_load(20'h00203);
        edges = 0;
        while (edges < 200 && pump_up === 1'b0 && pump_down === 1'b0) begin
            prescaler_in = 1'b1;
            cyc(8);
            prescaler_in = 1'b0;
            cyc(8);
            edges++;
        end
        if (edges >= 200) begin
            fails++;
        end
        chk("swallow_edges", 16'(2 * SSP_PRE_LO_SMALL + 1), edges[15:0]);
        chk("pump_fv_swap", 16'h2, {14'h0, pump_up, pump_down});
        chk("lock_fv_low", 16'h0, {15'h0, lock_indicator});
        chk("mon_fv2", 16'h2, mon_hits[15:0]);
        summarize();
    end
endmodule : ssp_top_tb_top
